// ### tcm_defs.vh
// Register map, field positions, reset values and mode codes for the timer channel config block.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef TCM_DEFS_VH
`define TCM_DEFS_VH
// ----------------------------------------
// Register word offsets (byte addresses)
// ----------------------------------------
`define TCM_OFS_MODE0     8'h00
`define TCM_OFS_MODE1     8'h04
`define TCM_OFS_MODE2     8'h08
`define TCM_OFS_MODE3     8'h0C
`define TCM_OFS_MODE4     8'h10
`define TCM_OFS_IOH0      8'h14
`define TCM_OFS_IOL0      8'h18
`define TCM_OFS_IO1       8'h1C
`define TCM_OFS_IO2       8'h20
`define TCM_OFS_IOH3      8'h24
`define TCM_OFS_IOL3      8'h28
`define TCM_OFS_IOH4      8'h2C
`define TCM_OFS_IOL4      8'h30
`define TCM_OFS_CLKSEL3   8'h34
`define TCM_OFS_CLKSEL4   8'h38
`define TCM_OFS_CNT3      8'h3C
`define TCM_OFS_CNT4      8'h40
// ----------------------------------------
// Reset values and fields
// ----------------------------------------
`define TCM_MODE_RST      8'hC0
`define TCM_IO_RST        8'h00
`define TCM_MODE_FIXED    8'hC0
`define TCM_BUF_B_BIT     5
`define TCM_BUF_A_BIT     4
// ----------------------------------------
// Operating mode codes
// ----------------------------------------
`define TCM_MD_NORMAL     4'h0
`define TCM_MD_PWM1       4'h2
`define TCM_MD_PWM2       4'h3
`define TCM_MD_RSTSYNC    4'h8
`define TCM_MD_CPWM1      4'hD
`define TCM_MD_CPWM2      4'hE
`define TCM_MD_CPWM3      4'hF
// ----------------------------------------
// Clock source codes and prescale widths
// ----------------------------------------
`define TCM_CS_EXT_A      3'h6
`define TCM_CS_EXT_B      3'h7
`define TCM_PRE_W         10
`endif

// ### tcm_timer_cfg.v
// Mode and compare/capture configuration for timer channels 0 to 4, buffer pairing for channels 0, 3 and 4,
// plus clock-source selection and counters for channels 3 and 4.
// Assumes a classic Wishbone master on mclk and external clock pins from another domain.
//
// The register addresses and the Wishbone slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "tcm_defs.vh"
module tcm_timer_cfg #(
   parameter CNT_W = 16                   // Channel counter width
) (
   input  wire        mclk,               // Peripheral clock, 25 MHz
   input  wire        sys_rst,            // Power-on or standby reset, async high
   input  wire        clk_en,             // Freezes all state when low
   input  wire        manual_rst,         // Manual reset, config kept
   input  wire        wb_cyc_i,           // Wishbone cycle
   input  wire        wb_stb_i,           // Wishbone strobe
   input  wire        wb_we_i,            // Wishbone write
   input  wire [7:0]  wb_adr_i,           // Wishbone byte address
   input  wire [3:0]  wb_sel_i,           // Wishbone byte select
   input  wire [31:0] wb_dat_i,           // Wishbone write data
   output reg  [31:0] wb_dat_o,           // Wishbone read data
   output reg         wb_ack_o,           // Wishbone acknowledge
   output reg         wb_err_o,           // Unmapped address answer
   input  wire        ext_clock_pin_a,    // External clock pin A
   input  wire        ext_clock_pin_b,    // External clock pin B
   output reg  [4:0]  eff_mode_valid,     // Effective mode code is a legal one
   output reg  [19:0] eff_mode,           // Effective mode field per channel
   output reg  [4:0]  pwm_active,         // Channel in a PWM mode
   output reg  [4:0]  phase_active,       // Channel in phase counting
   output reg  [4:0]  sync_pwm_active,    // Channel in reset-sync/complementary PWM
   output reg  [19:0] gr_is_capture,      // Per channel A..D: capture duty
   output reg  [19:0] gr_is_compare,      // Per channel A..D: compare output duty
   output reg  [19:0] gr_is_buffer,       // Per channel A..D: acting as buffer
   output reg  [CNT_W-1:0] channel_counter_3, // Channel 3 counter
   output reg  [CNT_W-1:0] channel_counter_4  // Channel 4 counter
);

   // ----------------------------------------
   // Register storage
   // ----------------------------------------
   reg  [5:0]  mode_with_buffer_ctrl_r [0:4]; // Low six bits; ch1/2 use four
   reg  [7:0]  io_control_reg_r [0:7];   // 0:H0 1:L0 2:ch1 3:ch2 4:H3 5:L3 6:H4 7:L4
   reg  [2:0]  clock_source_select_3_r;  // Ch3 clock source
   reg  [2:0]  clock_source_select_4_r;  // Ch4 clock source
   reg  [`TCM_PRE_W-1:0] prescale_r;     // Free running prescaler
   reg  [1:0]  pin_a_sync_r;             // Pin A synchroniser
   reg  [1:0]  pin_b_sync_r;             // Pin B synchroniser
   reg         pin_a_prev_r;             // Pin A previous synced level
   reg         pin_b_prev_r;             // Pin B previous synced level
   reg  [`TCM_PRE_W-1:0] prescale_nxt;   // Prescaler next value

   wire        bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o; // New request
   wire        bus_wr  = bus_req & wb_we_i & wb_sel_i[0];             // Low lane write

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   reg  [4:0]  adr_idx;                  // Register index 0..16
   reg         adr_hit;                  // Mapped address
   always @* begin
      adr_idx = 5'h00;
      adr_hit = 1'b0;
      if (wb_adr_i[1:0] == 2'b00 && wb_adr_i <= `TCM_OFS_CNT4) begin
         adr_idx = wb_adr_i[6:2];
         adr_hit = 1'b1;
      end
   end

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   // Only sys_rst (power-on/standby) clears; manual_rst deliberately unused here
   genvar g;
   generate
      for (g = 0; g < 5; g = g + 1) begin : g_mode
         always @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) begin
               mode_with_buffer_ctrl_r[g] <= 6'h00;
            end else if (clk_en && bus_wr && adr_hit && adr_idx == g) begin
               if (g == 1 || g == 2) begin
                  mode_with_buffer_ctrl_r[g] <= {2'b00, wb_dat_i[3:0]};
               end else begin
                  mode_with_buffer_ctrl_r[g] <= wb_dat_i[5:0];
               end
            end
         end
      end
      for (g = 0; g < 8; g = g + 1) begin : g_io
         always @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) begin
               io_control_reg_r[g] <= `TCM_IO_RST;
            end else if (clk_en && bus_wr && adr_hit && adr_idx == g + 5) begin
               io_control_reg_r[g] <= wb_dat_i[7:0];
            end
         end
      end
   endgenerate

   // Clock selects for channels 3 and 4
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         clock_source_select_3_r <= 3'h0;
         clock_source_select_4_r <= 3'h0;
      end else if (clk_en && bus_wr && adr_hit) begin
         if (adr_idx == 5'd13) begin
            clock_source_select_3_r <= wb_dat_i[2:0];
         end
         if (adr_idx == 5'd14) begin
            clock_source_select_4_r <= wb_dat_i[2:0];
         end
      end
   end

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   reg  [31:0] rd_data;                  // Combinational read value
   always @* begin
      rd_data = 32'h00000000;
      if (adr_idx < 5'd5) begin
         rd_data[7:0] = `TCM_MODE_FIXED | {2'b00, mode_with_buffer_ctrl_r[adr_idx[2:0]]};
      end else if (adr_idx < 5'd13) begin
         rd_data[7:0] = io_control_reg_r[adr_idx[2:0] - 3'd5];
      end else if (adr_idx == 5'd13) begin
         rd_data[2:0] = clock_source_select_3_r;
      end else if (adr_idx == 5'd14) begin
         rd_data[2:0] = clock_source_select_4_r;
      end else if (adr_idx == 5'd15) begin
         rd_data[CNT_W-1:0] = channel_counter_3;
      end else begin
         rd_data[CNT_W-1:0] = channel_counter_4;
      end
   end

   // ----------------------------------------
   // Wishbone answer: one cycle after request
   // ----------------------------------------
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else if (clk_en) begin
         wb_ack_o <= bus_req & adr_hit;
         wb_err_o <= bus_req & ~adr_hit;  // Unmapped gets error
         if (bus_req && adr_hit) begin
            wb_dat_o <= rd_data;
         end
      end
   end

   // ----------------------------------------
   // Effective modes and IO duty decode
   // ----------------------------------------
   reg  [3:0] md_raw [0:4];              // Written mode fields
   reg  [3:0] md_eff;                    // Effective field for channel
   reg        ch3_sync;                  // Channel 3 in sync PWM
   reg  [7:0] hi_reg;                    // High/single IO register
   reg  [7:0] lo_reg;                    // Low IO register
   reg  [3:0] fld;                       // Current IO field
   reg        buf_a;                     // A/C paired
   reg        buf_b;                     // B/D paired
   reg  [19:0] cap_nxt, cmp_nxt, buf_nxt, md_nxt; // Decoded vectors
   reg  [4:0]  pwm_nxt, ph_nxt, sy_nxt, val_nxt;   // Decoded flags
   integer c, k;
   always @* begin
      cap_nxt = 20'h00000;
      cmp_nxt = 20'h00000;
      buf_nxt = 20'h00000;
      md_nxt  = 20'h00000;
      pwm_nxt = 5'h00;
      ph_nxt  = 5'h00;
      sy_nxt  = 5'h00;
      val_nxt = 5'h00;
      md_eff  = 4'h0;
      hi_reg  = 8'h00;
      lo_reg  = 8'h00;
      fld     = 4'h0;
      buf_a   = 1'b0;
      buf_b   = 1'b0;
      for (c = 0; c < 5; c = c + 1) begin
         md_raw[c] = mode_with_buffer_ctrl_r[c][3:0];
      end
      ch3_sync = (md_raw[3] == `TCM_MD_RSTSYNC) || (md_raw[3] >= `TCM_MD_CPWM1);
      for (c = 0; c < 5; c = c + 1) begin
         md_eff = md_raw[c];
         if (c == 4 && ch3_sync) begin
            md_eff = md_raw[3];
         end
         md_nxt[c*4 +: 4] = md_eff;
         // Legal codes only; software keeps reserved ones out
         case (md_eff)
            `TCM_MD_NORMAL: val_nxt[c] = 1'b1;
            `TCM_MD_PWM1: begin
               val_nxt[c] = 1'b1;
               pwm_nxt[c] = 1'b1;
            end
            `TCM_MD_PWM2: begin
               val_nxt[c] = 1'b1;
               pwm_nxt[c] = 1'b1;
            end
            4'h4, 4'h5, 4'h6, 4'h7: begin
               val_nxt[c] = 1'b1;
               ph_nxt[c]  = 1'b1;
            end
            `TCM_MD_RSTSYNC, `TCM_MD_CPWM1, `TCM_MD_CPWM2, `TCM_MD_CPWM3: begin
               val_nxt[c] = 1'b1;
               pwm_nxt[c] = 1'b1;
               sy_nxt[c]  = 1'b1;
            end
            default: val_nxt[c] = 1'b0;
         endcase
         // Locate this channel's IO registers
         case (c)
            0: begin
               hi_reg = io_control_reg_r[0];
               lo_reg = io_control_reg_r[1];
            end
            1: begin
               hi_reg = io_control_reg_r[2];
               lo_reg = 8'h00;
            end
            2: begin
               hi_reg = io_control_reg_r[3];
               lo_reg = 8'h00;
            end
            3: begin
               hi_reg = io_control_reg_r[4];
               lo_reg = io_control_reg_r[5];
            end
            default: begin
               hi_reg = io_control_reg_r[6];
               lo_reg = io_control_reg_r[7];
            end
         endcase
         buf_a = mode_with_buffer_ctrl_r[c][`TCM_BUF_A_BIT];
         buf_b = mode_with_buffer_ctrl_r[c][`TCM_BUF_B_BIT];
         buf_nxt[c*4+2] = buf_a;
         buf_nxt[c*4+3] = buf_b;
         for (k = 0; k < 4; k = k + 1) begin
            case (k)
               0: fld = hi_reg[3:0];
               1: fld = hi_reg[7:4];
               2: fld = buf_a ? 4'h0 : lo_reg[3:0];
               default: fld = buf_b ? 4'h0 : lo_reg[7:4];
            endcase
            // 0x00 disables; 1xxx captures; other 0xyy compare
            cap_nxt[c*4+k] = fld[3];
            cmp_nxt[c*4+k] = ~fld[3] & (fld[1:0] != 2'b00);
         end
      end
   end

   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         eff_mode        <= 20'h00000;
         eff_mode_valid  <= 5'h1F;
         pwm_active      <= 5'h00;
         phase_active    <= 5'h00;
         sync_pwm_active <= 5'h00;
         gr_is_capture   <= 20'h00000;
         gr_is_compare   <= 20'h00000;
         gr_is_buffer    <= 20'h00000;
      end else if (clk_en) begin
         eff_mode        <= md_nxt;
         eff_mode_valid  <= val_nxt;
         pwm_active      <= pwm_nxt;
         phase_active    <= ph_nxt;
         sync_pwm_active <= sy_nxt;
         gr_is_capture   <= cap_nxt;
         gr_is_compare   <= cmp_nxt;
         gr_is_buffer    <= buf_nxt;
      end
   end

   // ----------------------------------------
   // Clock sources and channel 3/4 counters
   // ----------------------------------------
   always @* begin
      prescale_nxt = prescale_r + {{(`TCM_PRE_W-1){1'b0}}, 1'b1};
   end

   // Code 0 ticks every cycle, 1 to 5 when the divider's low bits wrap, 6 and 7 on synced pin edges
   function src_tick;
      input [2:0]           sel;
      input [`TCM_PRE_W-1:0] pre;
      input                 rise_a;
      input                 rise_b;
      begin
         case (sel)
            3'h0: src_tick = 1'b1;
            3'h1: src_tick = (pre[1:0] == 2'h3);
            3'h2: src_tick = (pre[3:0] == 4'hF);
            3'h3: src_tick = (pre[5:0] == 6'h3F);
            3'h4: src_tick = (pre[7:0] == 8'hFF);
            3'h5: src_tick = (pre[9:0] == 10'h3FF);
            `TCM_CS_EXT_A: src_tick = rise_a;
            default: src_tick = rise_b;
         endcase
      end
   endfunction

   wire rise_a = pin_a_sync_r[1] & ~pin_a_prev_r;   // Synced rising edge
   wire rise_b = pin_b_sync_r[1] & ~pin_b_prev_r;   // Synced rising edge

   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         prescale_r        <= {`TCM_PRE_W{1'b0}};
         pin_a_sync_r      <= 2'b00;
         pin_b_sync_r      <= 2'b00;
         pin_a_prev_r      <= 1'b0;
         pin_b_prev_r      <= 1'b0;
         channel_counter_3 <= {CNT_W{1'b0}};
         channel_counter_4 <= {CNT_W{1'b0}};
      end else if (clk_en) begin
         // Two stages before the edge detector sees the pins
         pin_a_sync_r <= {pin_a_sync_r[0], ext_clock_pin_a};
         pin_b_sync_r <= {pin_b_sync_r[0], ext_clock_pin_b};
         pin_a_prev_r <= pin_a_sync_r[1];
         pin_b_prev_r <= pin_b_sync_r[1];
         prescale_r   <= prescale_nxt;
         if (src_tick(clock_source_select_3_r, prescale_r, rise_a, rise_b)) begin
            channel_counter_3 <= channel_counter_3 + {{(CNT_W-1){1'b0}}, 1'b1};
         end
         if (src_tick(clock_source_select_4_r, prescale_r, rise_a, rise_b)) begin
            channel_counter_4 <= channel_counter_4 + {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // manual_rst intentionally leaves configuration untouched
   wire unused_ok = manual_rst | (|wb_sel_i[3:1]) | (|wb_dat_i[31:8]) | (|wb_adr_i[7]);

endmodule // tcm_timer_cfg
`default_nettype wire

// ### tcm_timer_cfg_monitor.sv
// Checker for the timer channel config block: bus answers, read-back fields, decode flags.
// Assumes it is bound to tcm_timer_cfg and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module tcm_timer_cfg_monitor #(
   parameter CNT_W = 16                        // Counter width, as in the design
) (
   input wire logic             mclk,           // Peripheral clock
   input wire logic             sys_rst,        // Async reset, high
   input wire logic             clk_en,         // Clock enable
   input wire logic             wb_cyc_i,       // Bus cycle
   input wire logic             wb_stb_i,       // Bus strobe
   input wire logic             wb_we_i,        // Bus write
   input wire logic [7:0]       wb_adr_i,       // Bus address
   input wire logic [31:0]      wb_dat_o,       // Read data
   input wire logic             wb_ack_o,       // Acknowledge
   input wire logic             wb_err_o,       // Error answer
   input wire logic [19:0]      eff_mode,       // Effective modes
   input wire logic [4:0]       pwm_active,     // PWM flags
   input wire logic [4:0]       phase_active,   // Phase flags
   input wire logic [4:0]       sync_pwm_active, // Sync PWM flags
   input wire logic [19:0]      gr_is_capture,  // Capture duty
   input wire logic [19:0]      gr_is_compare,  // Compare duty
   input wire logic [19:0]      gr_is_buffer,   // Buffer duty
   input wire logic [CNT_W-1:0] channel_counter_3 // Channel 3 counter
);
   // One domain only, so clock and reset are given once
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // ----------------------------------------
   // Bus answers
   // ----------------------------------------
   property p_answer;
      (wb_cyc_i && wb_stb_i && clk_en && !wb_ack_o && !wb_err_o) |=> (wb_ack_o || wb_err_o);
   endproperty
   a_answer: assert property (p_answer) else $error("request not answered next cycle");
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   // Address still held at the ack edge, so it names the register read
   property p_mode_top;
      (wb_ack_o && !wb_we_i && wb_adr_i <= 8'h10 && wb_adr_i[1:0] == 2'h0)
         |-> wb_dat_o[7:6] == 2'h3;
   endproperty
   a_mode_top: assert property (p_mode_top) else $error("mode top bits not one");
   property p_buf_fixed;
      (wb_ack_o && !wb_we_i && (wb_adr_i == 8'h04 || wb_adr_i == 8'h08)) |-> wb_dat_o[5:4] == 2'h0;
   endproperty
   a_buf_fixed: assert property (p_buf_fixed) else $error("ch1/2 buffer bits not zero");
   // ----------------------------------------
   // Decode relations
   // ----------------------------------------
   property p_buf_d;
      gr_is_buffer[3] |-> !gr_is_capture[3] && !gr_is_compare[3];
   endproperty
   a_buf_d: assert property (p_buf_d) else $error("buffered D still active");
   property p_buf_c;
      gr_is_buffer[2] |-> !gr_is_capture[2] && !gr_is_compare[2];
   endproperty
   a_buf_c: assert property (p_buf_c) else $error("buffered C still active");
   property p_pwm1;
      (eff_mode[7:4] == 4'h2 || eff_mode[7:4] == 4'h3) |-> pwm_active[1] && !phase_active[1];
   endproperty
   a_pwm1: assert property (p_pwm1) else $error("ch1 PWM flag wrong");
   property p_phase1;
      (eff_mode[7:6] == 2'h1) |-> phase_active[1] && !pwm_active[1];
   endproperty
   a_phase1: assert property (p_phase1) else $error("ch1 phase flag wrong");
   property p_sync3;
      (eff_mode[15:12] == 4'h8 || eff_mode[15:12] >= 4'hD) |-> sync_pwm_active[3];
   endproperty
   a_sync3: assert property (p_sync3) else $error("ch3 sync flag missing");
   property p_follow;
      sync_pwm_active[3] |-> eff_mode[19:16] == eff_mode[15:12];
   endproperty
   a_follow: assert property (p_follow) else $error("ch4 not following ch3");
   // Counter never jumps by more than one per clock
   property p_step;
      $changed(channel_counter_3) |-> channel_counter_3 == $past(channel_counter_3) + 1'b1;
   endproperty
   a_step: assert property (p_step) else $error("counter jumped");
   // ----------------------------------------
   // Coverage of main scenarios
   // ----------------------------------------
   c_sync: cover property (sync_pwm_active[3]);
   c_buf: cover property (gr_is_buffer[3] && gr_is_buffer[2]);
   c_phase: cover property (phase_active[1]);
   c_err: cover property (wb_err_o);
endmodule // tcm_timer_cfg_monitor
bind tcm_timer_cfg tcm_timer_cfg_monitor #(.CNT_W(CNT_W)) u_mon (.mclk(mclk), .sys_rst(sys_rst),
   .clk_en(clk_en), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
   .eff_mode(eff_mode), .pwm_active(pwm_active), .phase_active(phase_active),
   .sync_pwm_active(sync_pwm_active), .gr_is_capture(gr_is_capture),
   .gr_is_compare(gr_is_compare), .gr_is_buffer(gr_is_buffer),
   .channel_counter_3(channel_counter_3));
`default_nettype wire

// ### test_timer_channel_mode_config.sv
// Self-checking bench for the timer channel config block, driven over classic Wishbone.
// Assumes the design and its header are compiled first; one 25 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module test_timer_channel_mode_config;
   logic        mclk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, manual_rst = 1'b0; // Controls
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, pa = 1'b0, pb = 1'b0; // Bus and pins
   logic [7:0]  adr = 8'h00;                   // Address
   logic [3:0]  sel = 4'h0;                    // Byte select
   logic [31:0] wd = 32'h0, rdat;              // Write data, read data
   logic        ack, err;                      // Bus answers
   logic [19:0] em, cap, cmp, buff;            // Decode outputs
   logic [4:0]  pwm, ph, syn, val;             // Mode flags, legal-code flags
   logic [15:0] c3, c4, s3, s4;                // Counters and snapshots
   logic [31:0] rv;                            // Read value
   logic        re;                            // Read error flag
   int          errors = 0, check_count = 0;   // Tallies
   int          i;                             // Loop index
   logic [3:0]  codes [4] = '{4'h8, 4'hD, 4'hE, 4'hF}; // Sync PWM codes
   // ----------------------------------------
   // Clock and design
   // ----------------------------------------
   always #20 mclk = ~mclk;
   tcm_timer_cfg u_dut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
      .manual_rst(manual_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
      .ext_clock_pin_a(pa), .ext_clock_pin_b(pb), .eff_mode_valid(val), .eff_mode(em),
      .pwm_active(pwm), .phase_active(ph), .sync_pwm_active(syn), .gr_is_capture(cap),
      .gr_is_compare(cmp), .gr_is_buffer(buff), .channel_counter_3(c3),
      .channel_counter_4(c4));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One classic cycle; answer taken at the edge that shows ack or err
   // No local limit: only the watchdog ends a wait for the answer
   task automatic xfer(input logic w, input logic [3:0] s, input logic [7:0] a,
                       input logic [31:0] d);
      @(posedge mclk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; sel <= s; adr <= a; wd <= d;
      do begin
         @(posedge mclk);
      end while (!(ack === 1'b1 || err === 1'b1));
      rv = rdat;
      re = err;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, 4'hF, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, 4'hF, a, 32'h0);
      chk(rv, exp);
      chk(re, 1'b0);
   endtask
   // Decode outputs lag a write by one cycle; sample clear of the edge
   task automatic settle;
      repeat (2) @(posedge mclk);
      #1;
   endtask
   task automatic end_of_test;
      if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ----------------------------------------
   // Watchdog, well beyond the ~6.5k cycle run
   // ----------------------------------------
   initial begin
      repeat (30000) @(posedge mclk);
      errors++;
      end_of_test;
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge mclk);
      sys_rst <= 1'b0;
      for (i = 0; i < 13; i++) rd(8'(i * 4), i < 5 ? 32'hC0 : 32'h0);
      wr(8'h00, 32'h00); rd(8'h00, 32'hC0);
      wr(8'h00, 32'h32); rd(8'h00, 32'hF2);
      wr(8'h04, 32'h33); rd(8'h04, 32'hC3);
      for (i = 5; i < 13; i++) wr(8'(i * 4), 32'hFFFF_FF00 | 32'(8'hA5 ^ 8'(i)));
      for (i = 5; i < 13; i++) rd(8'(i * 4), 32'(8'hA5 ^ 8'(i)));
      xfer(1'b1, 4'hE, 8'h1C, 32'h77); rd(8'h1C, 32'hA2); // Byte lane off: write ignored
      xfer(1'b0, 4'hF, 8'h44, 32'h0); chk(re, 1'b1); // Unmapped read refused
      xfer(1'b1, 4'hF, 8'h05, 32'h0); chk(re, 1'b1); // Unaligned write refused
      // Channel-1 mode codes 0 and 2 to 7, flags from the code itself
      for (i = 0; i < 8; i++) if (i != 1) begin
         wr(8'h04, 32'(i)); settle;
         chk(em[7:4], 4'(i));
         chk({pwm[1], ph[1]}, {i == 2 || i == 3, i >= 4});
         chk(val, 5'h1F);
      end
      // Channel 4 follows channel 3 in the sync PWM codes
      wr(8'h10, 32'h02);
      for (i = 0; i < 4; i++) begin
         wr(8'h0C, 32'(codes[i])); settle;
         chk({syn[3], em[15:12], em[19:16]}, {1'b1, codes[i], codes[i]});
      end
      wr(8'h0C, 32'h00); settle; chk(em[19:16], 4'h2);
      // Buffer pairing silences C and D on channel 0
      wr(8'h14, 32'h81); wr(8'h18, 32'h98); wr(8'h00, 32'h30); settle;
      chk({buff[3:0], cap[3:0], cmp[3:0]}, 12'hC21);
      wr(8'h00, 32'h00); settle;
      chk({buff[3:0], cap[3:0], cmp[3:0]}, 12'h0E1);
      // Manual reset keeps the configuration
      manual_rst <= 1'b1; repeat (3) @(posedge mclk); manual_rst <= 1'b0;
      rd(8'h14, 32'h81); rd(8'h00, 32'hC0);
      // Internal prescale codes over a 1024-cycle window
      for (i = 0; i < 6; i++) begin
         wr(8'h34, 32'(i)); settle;
         s3 = c3;
         repeat (1024) @(posedge mclk);
         #1 chk(c3 - s3, 32'(1024 >> (2 * i)));
      end
      // External pins: ten edges on A for ch3, five on B for ch4
      wr(8'h34, 32'h6); wr(8'h38, 32'h7); settle;
      s3 = c3; s4 = c4;
      for (i = 0; i < 10; i++) begin
         @(posedge mclk); pa <= 1'b1; pb <= (i < 5);
         repeat (2) @(posedge mclk); pa <= 1'b0; pb <= 1'b0;
         repeat (2) @(posedge mclk);
      end
      repeat (6) @(posedge mclk);
      #1 chk({c3 - s3, c4 - s4}, {16'd10, 16'd5});
      // Clock enable low freezes the counter
      wr(8'h34, 32'h0); settle;
      @(posedge mclk); clk_en <= 1'b0;
      #1 s3 = c3;
      repeat (40) @(posedge mclk);
      #1 chk(c3, s3);
      @(posedge mclk); clk_en <= 1'b1;
      // Counter steps once before the request is taken and read out
      rd(8'h3C, 32'(s3) + 32'h1);
      end_of_test;
   end
endmodule // test_timer_channel_mode_config
`default_nettype wire
